// ===== logic/bbid_defs.svh
`ifndef BBID_DEFS_SVH
`define BBID_DEFS_SVH

// upper opcode nibbles
`define BBID_NIB_CTRL0 4'h0
`define BBID_NIB_LOGIC 4'h1
`define BBID_NIB_ARITH 4'h2
`define BBID_NIB_ROTC 4'h3
`define BBID_NIB_ROTN 4'h4
`define BBID_NIB_SUBS 4'h5
`define BBID_NIB_CMP 4'h6
`define BBID_NIB_BIT_TOGGLE 4'h7
`define BBID_NIB_BIT_SET 4'h8
`define BBID_NIB_BIT_CLEAR 4'h9
`define BBID_NIB_TEST_SET 4'hA
`define BBID_NIB_TEST_CLEAR 4'hB
`define BBID_NIB_FILE_PAIR 4'hC
`define BBID_NIB_REL 4'hD
`define BBID_NIB_BRANCH 4'hE
`define BBID_NIB_WORD2 4'hF

// status flag masks, bit 0 carry, 1 digit carry, 2 zero, 3 overflow, 4 negative
`define BBID_FM_NONE 5'h00
`define BBID_FM_ALL 5'h1F
`define BBID_FM_ZN 5'h14
`define BBID_FM_CZN 5'h15
`define BBID_FM_Z 5'h04

// access bank split
`define BBID_ACCESS_SPLIT 8'h80
`define BBID_ACCESS_LOW 4'h0
`define BBID_ACCESS_HIGH 4'hF

// register map and reset values
`define BBID_REG_BANK 4'h0
`define BBID_REG_STATUS 4'h4
`define BBID_REG_LAST 4'h8
`define BBID_BANK_RESET 4'h0

`endif

// ===== logic/bbid_pkg.sv
package bbid_pkg;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_WORD2 = 2'b01,
    ST_FLUSH = 2'b11,
    ST_FLUSH2 = 2'b10
  } bbid_state_t;

  typedef enum logic [4:0] {
    ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_RSUBB, ALU_INC, ALU_DEC,
    ALU_NEG, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_RLC, ALU_RRC, ALU_RL, ALU_RR,
    ALU_SWAP, ALU_PASS, ALU_STORE_ACC, ALU_CLR, ALU_SET, ALU_MUL, ALU_BCLR,
    ALU_BSET, ALU_BTOG, ALU_LIT
  } bbid_alu_t;

  typedef enum logic [3:0] {
    SK_NONE, SK_INC_Z, SK_INC_NZ, SK_DEC_Z, SK_DEC_NZ, SK_CMP_EQ, SK_CMP_GT,
    SK_CMP_LT, SK_TST_Z, SK_BIT_SET, SK_BIT_CLR, SK_BR_COND, SK_ALWAYS
  } bbid_skip_t;

  typedef enum logic [2:0] {
    TW_NONE, TW_MOVE, TW_JUMP, TW_CALL, TW_LIT12
  } bbid_tw_t;

  typedef struct packed {
    bbid_alu_t alu;
    bbid_skip_t skip;
    bbid_tw_t tw;
    logic [4:0] flags;
    logic usesFile;
    logic hasDest;
    logic wrFile;
    logic wrAcc;
    logic isRet;
  } bbid_dec_t;

endpackage

// ===== logic/bbid_skip_eval.sv
`timescale 1ns/10ps
module bbid_skip_eval
  import bbid_pkg::*;
(
  // test selection
  input wire bbid_skip_t kind,
  input wire logic [2:0] bitPos,
  input wire logic [2:0] cond,
  // operands
  input wire logic [7:0] operand,
  input wire logic [7:0] acc,
  input wire logic [4:0] flags,
  // outcome
  output logic take
);

  logic [7:0] incVal;
  logic [7:0] decVal;
  logic condFlag;

  always_comb
  begin
    incVal = operand + 8'h01;
    decVal = operand - 8'h01;
    // branch condition: pairs of zero, carry, overflow, negative; odd code negates
    case (cond[2:1])
      2'b00: condFlag = flags[2];
      2'b01: condFlag = flags[0];
      2'b10: condFlag = flags[3];
      default: condFlag = flags[4];
    endcase
    case (kind)
      SK_INC_Z: take = (incVal == 8'h00);
      SK_INC_NZ: take = (incVal != 8'h00);
      SK_DEC_Z: take = (decVal == 8'h00);
      SK_DEC_NZ: take = (decVal != 8'h00);
      SK_CMP_EQ: take = (operand == acc);
      SK_CMP_GT: take = (operand > acc);
      SK_CMP_LT: take = (operand < acc);
      SK_TST_Z: take = (operand == 8'h00);
      SK_BIT_SET: take = operand[bitPos];
      SK_BIT_CLR: take = !operand[bitPos];
      SK_BR_COND: take = condFlag ^ cond[0];
      SK_ALWAYS: take = 1'b1;
      default: take = 1'b0;
    endcase
  end

endmodule // bbid_skip_eval

// ===== logic/bbid_decoder.sv
// Overview of operation
// - file address low byte; d picks destination
// - a=0 access bank, a=1 bank select
// - two-word file move, 12-bit addresses, no flags
// - bit ops: position, a, address; no flags
// - literal operand is the low byte
// - absolute jump target 20 bits over two words
// - call fast bit passed to call logic
// - fast bit alone triggers shadow save/restore
// - relative offsets 11 bits or 8 bits signed
// - port operand read from pins, not latch
// - timer count file op clears its prescaler; ops with d=0 and file pair moves into the timer do not clear it
// - pc change or true test costs two cycles, three when the test skips a two-word instruction
// - lone second word executes as no-operation
// - compare and test skips, no flags
// - increment/decrement skips write per d, no flags
// - logical operations update zero and negative only
// - subtract, negate, increment, decrement update five flags
// - rotate and swap flag updates as listed
// - multiply, store, move, clear, set decode
// - product high and low bytes from multiply
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "bbid_defs.svh"
module bbid_decoder
  import bbid_pkg::*;
#(
  parameter logic [11:0] PORT_B_ADDR = 12'hF00,
  parameter logic [11:0] TIMER_ZERO_ADDR = 12'hF01
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // instruction fetch
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  // datapath operands
  output logic [11:0] operandAddr,
  input wire logic [7:0] fileData,
  input wire logic [7:0] portPins,
  input wire logic [7:0] accData,
  input wire logic [4:0] statusFlags,
  input wire logic prescalerAssigned,
  // decoded execution controls
  output logic execValid,
  output logic execNop,
  output logic squash,
  output bbid_alu_t aluFunc,
  output logic [4:0] flagMask,
  output logic writeFile,
  output logic writeAcc,
  output logic [11:0] fileAddr,
  output logic [2:0] bitPos,
  output logic [7:0] literal,
  output logic [7:0] operandValue,
  output logic readPins,
  output logic prescalerClear,
  // program flow
  output logic pcRel,
  output logic [10:0] relOffset,
  output logic pcLoad,
  output logic [19:0] pcTarget,
  output logic callPush,
  output logic retPop,
  output logic fastSel,
  output logic shadowSave,
  output logic shadowRestore,
  // file pair move and product
  output logic moveWrite,
  output logic [11:0] moveSrcAddr,
  output logic [11:0] moveDstAddr,
  output logic [7:0] productHigh,
  output logic [7:0] productLow
);

  function automatic bbid_dec_t decodeWord(input logic [15:0] w);
    bbid_dec_t d;
    d = '{alu: ALU_NONE, skip: SK_NONE, tw: TW_NONE, flags: `BBID_FM_NONE, default: 1'b0};
    d.usesFile = 1'b1;
    d.hasDest = 1'b1;
    case (w[15:12])
      `BBID_NIB_CTRL0:
      begin
        d.hasDest = 1'b0;
        if (w[11:10] == 2'b01)
        begin
          d.alu = ALU_DEC;
          d.flags = `BBID_FM_ALL;
          d.hasDest = 1'b1;
        end
        else if (w[11:9] == 3'b001)
          d.alu = ALU_MUL;
        else
        begin
          d.usesFile = 1'b0;
          if (w[11])
          begin
            d.alu = ALU_LIT;
            d.wrAcc = 1'b1;
          end
          d.isRet = (w[11:1] == 11'h009);
        end
      end
      `BBID_NIB_LOGIC:
      begin
        d.flags = `BBID_FM_ZN;
        case (w[11:10])
          2'b00: d.alu = ALU_OR;
          2'b01: d.alu = ALU_AND;
          2'b10: d.alu = ALU_XOR;
          default: d.alu = ALU_COM;
        endcase
      end
      `BBID_NIB_ARITH:
      begin
        d.flags = `BBID_FM_ALL;
        case (w[11:10])
          2'b00: d.alu = ALU_ADDC;
          2'b01: d.alu = ALU_ADD;
          2'b10: d.alu = ALU_INC;
          default:
          begin
            d.alu = ALU_DEC;
            d.skip = SK_DEC_Z;
            d.flags = `BBID_FM_NONE;
          end
        endcase
      end
      `BBID_NIB_ROTC:
      begin
        case (w[11:10])
          2'b00: d.alu = ALU_RRC;
          2'b01: d.alu = ALU_RLC;
          2'b10: d.alu = ALU_SWAP;
          default: d.alu = ALU_INC;
        endcase
        d.flags = w[11] ? `BBID_FM_NONE : `BBID_FM_CZN;
        d.skip = (w[11:10] == 2'b11) ? SK_INC_Z : SK_NONE;
      end
      `BBID_NIB_ROTN:
      begin
        case (w[11:10])
          2'b00: d.alu = ALU_RR;
          2'b01: d.alu = ALU_RL;
          2'b10: d.alu = ALU_INC;
          default: d.alu = ALU_DEC;
        endcase
        d.flags = w[11] ? `BBID_FM_NONE : `BBID_FM_ZN;
        d.skip = !w[11] ? SK_NONE : (w[10] ? SK_DEC_NZ : SK_INC_NZ);
      end
      `BBID_NIB_SUBS:
      begin
        d.flags = (w[11:10] == 2'b00) ? `BBID_FM_ZN : `BBID_FM_ALL;
        case (w[11:10])
          2'b00: d.alu = ALU_PASS;
          2'b01: d.alu = ALU_RSUBB;
          2'b10: d.alu = ALU_SUBB;
          default: d.alu = ALU_SUB;
        endcase
      end
      `BBID_NIB_CMP:
      begin
        d.hasDest = 1'b0;
        d.wrFile = w[11];
        case (w[11:9])
          3'b000: d.skip = SK_CMP_LT;
          3'b001: d.skip = SK_CMP_EQ;
          3'b010: d.skip = SK_CMP_GT;
          3'b011: d.skip = SK_TST_Z;
          3'b100: d.alu = ALU_SET;
          3'b101:
          begin
            d.alu = ALU_CLR;
            d.flags = `BBID_FM_Z;
          end
          3'b110:
          begin
            d.alu = ALU_NEG;
            d.flags = `BBID_FM_ALL;
          end
          default: d.alu = ALU_STORE_ACC;
        endcase
      end
      `BBID_NIB_BIT_TOGGLE, `BBID_NIB_BIT_SET, `BBID_NIB_BIT_CLEAR:
      begin
        d.hasDest = 1'b0;
        d.wrFile = 1'b1;
        d.alu = (w[15:12] == `BBID_NIB_BIT_CLEAR) ? ALU_BCLR :
                (w[15:12] == `BBID_NIB_BIT_SET) ? ALU_BSET : ALU_BTOG;
      end
      `BBID_NIB_TEST_SET, `BBID_NIB_TEST_CLEAR:
      begin
        d.hasDest = 1'b0;
        d.skip = w[12] ? SK_BIT_CLR : SK_BIT_SET;
      end
      `BBID_NIB_FILE_PAIR:
      begin
        d.hasDest = 1'b0;
        d.tw = TW_MOVE;
      end
      `BBID_NIB_REL:
      begin
        d.usesFile = 1'b0;
        d.hasDest = 1'b0;
        d.skip = SK_ALWAYS;
      end
      `BBID_NIB_BRANCH:
      begin
        d.usesFile = 1'b0;
        d.hasDest = 1'b0;
        if (!w[11])
          d.skip = SK_BR_COND;
        else if (w[10:9] == 2'b10)
          d.tw = TW_CALL;
        else if (w[10:8] == 3'b111)
          d.tw = TW_JUMP;
        else if (w[10:8] == 3'b110)
          d.tw = TW_LIT12;
      end
      default:
      begin
        d.usesFile = 1'b0;
        d.hasDest = 1'b0;
      end
    endcase
    if (d.hasDest)
    begin
      d.wrFile = w[9];
      d.wrAcc = !w[9];
    end
    return d;
  endfunction

  // access bank maps the low half to bank 0 and the high half to the top bank
  function automatic logic [11:0] effAddr(input logic [7:0] f, input logic a,
                                          input logic [3:0] bank);
    if (a)
      return {bank, f};
    return {(f < `BBID_ACCESS_SPLIT) ? `BBID_ACCESS_LOW : `BBID_ACCESS_HIGH, f};
  endfunction

  bbid_state_t state;
  bbid_state_t next_state;
  bbid_dec_t dec;
  bbid_tw_t pendKind;
  logic [11:0] pendLow;
  logic pendFast;
  logic flushSkip;
  logic [3:0] bankSelect;
  logic [15:0] lastWord;
  logic busAck;
  logic [11:0] curAddr;
  logic [7:0] curOperand;
  logic hitPort;
  logic take;
  logic issue;
  logic flushWord;

  bbid_skip_eval skipEval (
    .kind(dec.skip),
    .bitPos(instrWord[11:9]),
    .cond(instrWord[10:8]),
    .operand(curOperand),
    .acc(accData),
    .flags(statusFlags),
    .take(take)
  );

  always_comb
  begin
    dec = decodeWord(instrWord);
    curAddr = effAddr(instrWord[7:0], instrWord[8], bankSelect);
    hitPort = dec.usesFile && (curAddr == PORT_B_ADDR);
    curOperand = hitPort ? portPins : fileData;
    operandAddr = curAddr;
    issue = instrValid && (state == ST_EXEC) && (instrWord[15:12] != `BBID_NIB_WORD2);
    flushWord = instrValid && ((state == ST_FLUSH) || (state == ST_FLUSH2));
  end

  always_comb
  begin
    next_state = state;
    if (instrValid)
    begin
      case (state)
        ST_EXEC:
          if (issue && (dec.tw != TW_NONE))
            next_state = ST_WORD2;
          else if (issue && (take || dec.isRet))
            next_state = ST_FLUSH;
        ST_WORD2: next_state = ST_EXEC;
        ST_FLUSH:
          next_state = (flushSkip && (dec.tw != TW_NONE)) ? ST_FLUSH2 : ST_EXEC;
        default: next_state = ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_EXEC;
      flushSkip <= 1'b0;
      pendKind <= TW_NONE;
      pendLow <= 12'h000;
      pendFast <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (issue)
      begin
        flushSkip <= (dec.skip != SK_ALWAYS) && (dec.skip != SK_BR_COND) && !dec.isRet;
        pendKind <= dec.tw;
        pendLow <= instrWord[11:0];
        pendFast <= instrWord[8];
      end
    end
  end

  // per-word controls; strobes are one-cycle pulses after the word's edge, operand fields hold until the next issued word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      execValid <= 1'b0;
      execNop <= 1'b0;
      squash <= 1'b0;
      aluFunc <= ALU_NONE;
      flagMask <= `BBID_FM_NONE;
      writeFile <= 1'b0;
      writeAcc <= 1'b0;
      fileAddr <= 12'h000;
      bitPos <= 3'h0;
      literal <= 8'h00;
      operandValue <= 8'h00;
      readPins <= 1'b0;
      prescalerClear <= 1'b0;
      pcRel <= 1'b0;
      relOffset <= 11'h000;
      retPop <= 1'b0;
      shadowRestore <= 1'b0;
      moveSrcAddr <= 12'h000;
    end
    else
    begin
      execValid <= instrValid;
      execNop <= flushWord || (instrValid && (state == ST_EXEC) && !issue);
      squash <= flushWord;
      aluFunc <= issue ? dec.alu : ALU_NONE;
      flagMask <= issue ? dec.flags : `BBID_FM_NONE;
      writeFile <= issue && dec.wrFile;
      writeAcc <= issue && dec.wrAcc;
      readPins <= issue && hitPort;
      prescalerClear <= issue && dec.usesFile && (curAddr == TIMER_ZERO_ADDR) &&
                        prescalerAssigned && (!dec.hasDest || instrWord[9]);
      pcRel <= issue && take && ((dec.skip == SK_ALWAYS) || (dec.skip == SK_BR_COND));
      retPop <= issue && dec.isRet;
      shadowRestore <= issue && dec.isRet && instrWord[0];
      if (issue)
      begin
        fileAddr <= curAddr;
        bitPos <= instrWord[11:9];
        literal <= instrWord[7:0];
        operandValue <= curOperand;
        relOffset <= (dec.skip == SK_ALWAYS) ? instrWord[10:0] :
                     {{3{instrWord[7]}}, instrWord[7:0]};
        if (dec.tw == TW_MOVE)
          moveSrcAddr <= instrWord[11:0];
      end
    end
  end

  // second word completes moves, jumps and calls
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      moveWrite <= 1'b0;
      moveDstAddr <= 12'h000;
      pcLoad <= 1'b0;
      pcTarget <= 20'h0_0000;
      callPush <= 1'b0;
      fastSel <= 1'b0;
      shadowSave <= 1'b0;
    end
    else
    begin
      moveWrite <= instrValid && (state == ST_WORD2) && (pendKind == TW_MOVE);
      pcLoad <= instrValid && (state == ST_WORD2) &&
                ((pendKind == TW_JUMP) || (pendKind == TW_CALL));
      callPush <= instrValid && (state == ST_WORD2) && (pendKind == TW_CALL);
      shadowSave <= instrValid && (state == ST_WORD2) && (pendKind == TW_CALL) &&
                    pendFast;
      if (instrValid && (state == ST_WORD2))
      begin
        moveDstAddr <= instrWord[11:0];
        pcTarget <= {instrWord[11:0], pendLow[7:0]};
        fastSel <= (pendKind == TW_CALL) && pendFast;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      productHigh <= 8'h00;
      productLow <= 8'h00;
    end
    else if (issue && (dec.alu == ALU_MUL))
      {productHigh, productLow} <= {8'h00, accData} * {8'h00, curOperand};
  end

  // register bus: one wait cycle per access, read data loaded in the wait cycle
  assign avs_waitrequest = (avs_read || avs_write) && !busAck;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busAck <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      bankSelect <= `BBID_BANK_RESET;
      lastWord <= 16'h0000;
    end
    else
    begin
      busAck <= (avs_read || avs_write) && !busAck;
      if (avs_write && busAck && (avs_address == `BBID_REG_BANK))
        bankSelect <= avs_writedata[3:0];
      if (issue)
        lastWord <= instrWord;
      if (avs_read && !busAck)
      begin
        case (avs_address)
          `BBID_REG_BANK: avs_readdata <= {28'h000_0000, bankSelect};
          `BBID_REG_STATUS: avs_readdata <= {27'h000_0000, pendKind, state};
          `BBID_REG_LAST: avs_readdata <= {16'h0000, lastWord};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_port_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && hitPort |=> readPins && (operandValue == $past(portPins)))
    else $error("port operand not taken from pins");
  a_timer_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    prescalerClear |-> $past(curAddr) == TIMER_ZERO_ADDR && $past(prescalerAssigned))
    else $error("prescaler cleared for wrong register");
  a_bit_ops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && (instrWord[15:12] inside {4'h7, 4'h8, 4'h9}) |=>
      flagMask == 5'h00 && writeFile && bitPos == $past(instrWord[11:9]))
    else $error("bit operation decoded wrongly");
  a_file_move: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && instrWord[15:12] == 4'hC ##1 instrValid |=>
      moveWrite && moveDstAddr == $past(instrWord[11:0]) && flagMask == 5'h00)
    else $error("file pair move not completed in two cycles");
  a_jump_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && instrWord[15:8] == 8'hEF ##1 instrValid |=>
      pcLoad && pcTarget == {$past(instrWord[11:0]), $past(instrWord[7:0], 2)})
    else $error("absolute jump target wrong");
  a_fast_call: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && instrWord[15:9] == 7'h76 ##1 instrValid |=>
      callPush && (shadowSave == $past(instrWord[8], 2)))
    else $error("shadow save does not follow fast bit");
  a_skip_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_FLUSH && flushSkip && instrValid && instrWord[15:12] == 4'hC |=>
      squash && state == ST_FLUSH2)
    else $error("skip over two-word instruction not three cycles");
  a_taken_flush: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && take && dec.tw == TW_NONE ##1 instrValid |=> squash && execNop)
    else $error("taken test without no-operation cycle");
  a_lone_word2: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instrValid && state == ST_EXEC && instrWord[15:12] == 4'hF |=>
      execNop && !writeFile && !writeAcc && flagMask == 5'h00)
    else $error("lone second word not a no-operation");
  a_access_bank: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && dec.usesFile && !instrWord[8] |=>
      fileAddr[11:8] == ($past(instrWord[7]) ? 4'hF : 4'h0))
    else $error("access bank not forced");
  a_bank_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && dec.usesFile && instrWord[8] |=> fileAddr[11:8] == $past(bankSelect))
    else $error("bank select not used");
  a_logic_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && instrWord[15:12] == 4'h1 |=> flagMask == 5'h14)
    else $error("logical operation flag mask wrong");
  a_product: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue && dec.alu == ALU_MUL |=>
      {productHigh, productLow} == 16'($past(accData) * $past(curOperand)))
    else $error("product bytes wrong");

endmodule // bbid_decoder

// ===== test/bbid_datapath_model.sv
`timescale 1ns/10ps
module bbid_datapath_model
(
  // address from the decoder
  input wire logic [11:0] operandAddr,
  // file contents, same cycle
  output logic [7:0] fileData
);
  // every location holds its low address byte plus an offset
  assign fileData = operandAddr[7:0] + 8'h11;
endmodule // bbid_datapath_model

// ===== test/test_byte_bit_instruction_decoder.sv
`timescale 1ns/10ps
module test_byte_bit_instruction_decoder
  import bbid_pkg::*;
;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic instrValid = 0;
  logic prescalerAssigned = 1;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] instrWord = 16'h0000;
  logic [7:0] fileData;
  logic [7:0] portPins = 8'hA5;
  logic [7:0] accData = 8'h31;
  logic [11:0] operandAddr, fileAddr, moveSrcAddr, moveDstAddr;
  logic execNop, squash, writeFile, writeAcc, readPins, prescalerClear, pcRel;
  logic pcLoad, callPush, fastSel, shadowSave, moveWrite;
  logic execValid, retPop, shadowRestore;
  bbid_alu_t aluFunc;
  logic [4:0] statusFlags = 5'h00;
  logic [31:0] rd;
  logic [4:0] flagMask;
  logic [2:0] bitPos;
  logic [7:0] literal, operandValue, productHigh, productLow;
  logic [10:0] relOffset;
  logic [19:0] pcTarget;
  int bad_count = 0;
  int compares = 0;

  always #10 ref_clk = ~ref_clk;

  bbid_decoder DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instrValid(instrValid), .instrWord(instrWord),
    .operandAddr(operandAddr), .fileData(fileData), .portPins(portPins), .accData(accData),
    .statusFlags(statusFlags), .prescalerAssigned(prescalerAssigned),
    .execValid(execValid), .execNop(execNop), .squash(squash), .aluFunc(aluFunc),
    .flagMask(flagMask), .writeFile(writeFile), .writeAcc(writeAcc), .fileAddr(fileAddr),
    .bitPos(bitPos), .literal(literal), .operandValue(operandValue), .readPins(readPins),
    .prescalerClear(prescalerClear), .pcRel(pcRel), .relOffset(relOffset),
    .pcLoad(pcLoad), .pcTarget(pcTarget), .callPush(callPush), .retPop(retPop),
    .fastSel(fastSel), .shadowSave(shadowSave), .shadowRestore(shadowRestore),
    .moveWrite(moveWrite), .moveSrcAddr(moveSrcAddr), .moveDstAddr(moveDstAddr),
    .productHigh(productHigh), .productLow(productLow));
  bbid_datapath_model mem (.operandAddr(operandAddr), .fileData(fileData));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk iff !avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task send(input logic [15:0] w);
    @(posedge ref_clk);
    instrWord <= w;
    instrValid <= 1'h1;
  endtask

  task take;
    @(posedge ref_clk);
    instrValid <= 1'h0;
    #1;
  endtask

  task one(input logic [15:0] w);
    send(w);
    take();
  endtask

  task t_regs;
    bus(1'h0, 4'h0, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'h1, 4'h0, 32'h0000_0003, rd);
    bus(1'h0, 4'h0, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0003);
    bus(1'h0, 4'hC, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_byte;
    logic [15:0] ops [9] = '{16'h1620, 16'h5E20, 16'h3620, 16'h3A20, 16'h6A20,
      16'h0620, 16'h0220, 16'h6E20, 16'h4AEE};
    logic [4:0] masks [9] = '{5'h14, 5'h1F, 5'h15, 5'h00, 5'h04, 5'h1F, 5'h00,
      5'h00, 5'h00};
    one(16'h1742);
    chk(fileAddr, 12'h342);
    chk(writeFile, 1'h1);
    chk(writeAcc, 1'h0);
    one(16'h1490);
    chk(fileAddr, 12'hF90);
    chk(writeAcc, 1'h1);
    for (int i = 0; i < 9; i++)
    begin
      one(ops[i]);
      chk(flagMask, masks[i]);
    end
    $display("test byte ops done");
  endtask

  task automatic t_bits;
    logic [3:0] nib [3] = '{4'h9, 4'h8, 4'h7};
    for (int i = 0; i < 3; i++)
    begin
      one({nib[i], 3'h5, 1'h0, 8'h10});
      chk(bitPos, 3'h5);
      chk(fileAddr, 12'h010);
      chk(flagMask, 5'h00);
    end
    $display("test bit ops done");
  endtask

  task t_flow;
    send(16'hC123);
    send(16'hF456);
    #1;
    chk(moveSrcAddr, 12'h123);
    take();
    chk(moveWrite, 1'h1);
    chk(moveDstAddr, 12'h456);
    send(16'hEF34);
    send(16'hF567);
    take();
    chk(pcLoad, 1'h1);
    chk(pcTarget, 20'h5_6734);
    send(16'hED12);
    send(16'hF001);
    take();
    chk(fastSel, 1'h1);
    chk(shadowSave, 1'h1);
    chk(callPush, 1'h1);
    send(16'hD7FF);
    send(16'h0000);
    #1;
    chk(pcRel, 1'h1);
    chk(relOffset, 11'h7FF);
    take();
    chk(squash, 1'h1);
    one(16'hF123);
    chk(execNop, 1'h1);
    one(16'h0E7F);
    chk(literal, 8'h7F);
    chk(aluFunc, ALU_LIT);
    $display("test flow done");
  endtask

  // equal compare skips a whole two-word instruction
  task t_skip;
    send(16'h6220);
    send(16'hC000);
    send(16'hF000);
    #1;
    chk(squash, 1'h1);
    send(16'h0000);
    #1;
    chk(squash, 1'h1);
    take();
    chk(squash, 1'h0);
    $display("test skip done");
  endtask

  task t_port;
    bus(1'h1, 4'h0, 32'h0000_000F, rd);
    one(16'h5300);
    chk(readPins, 1'h1);
    chk(operandValue, 8'hA5);
    one(16'h5301);
    chk(prescalerClear, 1'h1);
    one(16'h5101);
    chk(prescalerClear, 1'h0);
    @(posedge ref_clk);
    accData <= 8'h02;
    one(16'h0220);
    take();
    chk(productHigh, 8'h00);
    chk(productLow, 8'h62);
    $display("test port and product done");
  endtask

  // conditional branch, bit test skip and fast return
  task t_misc;
    @(posedge ref_clk);
    statusFlags <= 5'h04;
    one(16'hE0FE);
    chk(pcRel, 1'h1);
    chk(relOffset, 11'h7FE);
    one(16'h0000);
    chk(execNop, 1'h1);
    one(16'hE1FE);
    chk(pcRel, 1'h0);
    chk(execValid, 1'h1);
    one(16'hA020);
    one(16'h0000);
    chk(squash, 1'h1);
    one(16'h0013);
    chk(retPop, 1'h1);
    chk(shadowRestore, 1'h1);
    one(16'h0000);
    chk(squash, 1'h1);
    bus(1'h0, 4'h8, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0013);
    $display("test branch and return done");
  endtask

  task end_sim;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_regs();
    t_byte();
    t_bits();
    t_flow();
    t_skip();
    t_port();
    t_misc();
    end_sim();
  end

  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule // test_byte_bit_instruction_decoder
